// file: src/scb_defines.vh
// Constants for the system-control base/config register bank.
// Assumes inclusion by bare name from the design files; holds definitions only.
// Operation
// - Registers at 15 sel 2/3/4, 16 sel 0.
// - Region base exists only with capability bit set.
// - Master vproc bit clear: reads zero, writes ignored.
// - Bits 31:11 hold region address bits 35:15.
// - Bit 10 enables region, resets to zero.
// - Preset bit 9 reserves first block.
// - Bits 8:0 report block count minus one.
// - Unimplemented address bits read zero, ignore writes.
// - Coherency base bits mirror manager base field.
// - Coherency base exists only with capability, per processor.
// - Coherency base bits 10:0 read zero.
// - Boot vector bits 31:12 from pins; 11:8 zero.
// - Mask bits 7:0 size overlay over 27:20.
// - Only contiguous low-ones masks are supported.
// - Report overlay active in extended address mode. The bank has no extended address mode and no overlay-active report bit.
// - Configuration bit 31 reads one.
// - Upper kernel attr writable only with fixed MMU.
// - User attr writable only with fixed MMU.
// - Impl bits safe under RMW and zero writes.
// - Bit 15 reports running endianness.
// - Bits 14:13 report architecture type.
// - Kernel seg0 attr resets to uncached two.
`ifndef SCB_DEFINES_VH
`define SCB_DEFINES_VH
`define SCB_REGNUM_BASE 5'h0F
`define SCB_REGNUM_CFG 5'h10
`define SCB_SEL_REGION 3'h2
`define SCB_SEL_COH 3'h3
`define SCB_SEL_BOOT 3'h4
`define SCB_SEL_CFG 3'h0
`define SCB_ADDR_HI 31
`define SCB_ADDR_LO 11
`define SCB_ADDR_W 21
`define SCB_EN_BIT 10
`define SCB_RSV_BIT 9
`define SCB_CNT_HI 8
`define SCB_BOOT_LO 12
`define SCB_MASK_HI 7
`define SCB_CFG_M_BIT 31
`define SCB_K23_HI 30
`define SCB_K23_LO 28
`define SCB_KU_HI 27
`define SCB_KU_LO 25
`define SCB_IMPL_HI 24
`define SCB_IMPL_LO 16
`define SCB_BE_BIT 15
`define SCB_AT_HI 14
`define SCB_AT_LO 13
`define SCB_K0_HI 2
`define SCB_K0_RESET 3'h2
`define SCB_ATTR_ZERO 3'h0
`define SCB_ATTR_W 3
`define SCB_PA_BITS 5'h15
`endif

// file: src/scb_attr_check.v
// Cacheability attribute acceptance check for writable attribute fields.
// Assumes a combinational use by the register bank on the same clock.
`timescale 1ns/1ps
`include "scb_defines.vh"
module scb_attr_check (
  // Attribute value offered by a write
  input wire [2:0] attr_in,
  // Bit set of attribute encodings the core supports
  input wire [7:0] supported_set,
  // One when the value may be stored
  output wire attr_ok
);
  // Unsupported encodings leave the field untouched rather than storing junk
  assign attr_ok = supported_set[attr_in];
endmodule

// file: src/scb_regs.v
// Privileged register bank: region base, coherency base, boot vector, config word 0.
// Assumes core-clock access by register number/select with one-cycle read data.
`timescale 1ns/1ps
`include "scb_defines.vh"
module scb_regs #(
  parameter REGION_PRESENT = 1'b1,
  parameter COH_PRESENT = 1'b1,
  parameter MULTI_VPROC = 1'b1,
  parameter FIXED_MMU = 1'b1,
  parameter [4:0] PA_BITS = `SCB_PA_BITS,
  parameter REGION_MGMT_RSV = 1'b0,
  parameter [8:0] REGION_BLOCKS_M1 = 9'h000,
  parameter [1:0] ARCH_TYPE_VAL = 2'h0,
  parameter [7:0] ATTR_SUPPORTED = 8'hFF
) (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  input wire clk_en,
  // Privileged register access
  input wire acc_rd,
  input wire acc_wr,
  input wire [4:0] acc_regnum,
  input wire [2:0] acc_sel,
  input wire [31:0] acc_wdata,
  output reg [31:0] acc_rdata_reg,
  output reg acc_hit_reg,
  // Control and pin inputs
  input wire master_vproc_control,
  input wire [20:0] coherency_global_base_field,
  input wire [19:0] boot_exception_vector,
  input wire [7:0] boot_overlay_mask,
  input wire endian_flag,
  // Region controls towards the address decoder
  output reg region_enable_reg,
  output reg [20:0] region_upper_address_reg,
  output reg [2:0] kernel_seg0_attr_reg,
  output reg [2:0] user_seg_attr_reg,
  output reg [2:0] upper_kernel_seg_attr_reg,
  output reg [11:0] boot_overlay_reg
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: pins come from outside the clock domain
  reg [20:0] coh_s1_reg, coh_s2_reg;
  reg [19:0] bev_s1_reg, bev_s2_reg;
  reg [7:0] msk_s1_reg, msk_s2_reg;
  reg be_s1_reg, be_s2_reg, mvp_s1_reg, mvp_s2_reg;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      coh_s1_reg <= 21'h000000;
      coh_s2_reg <= 21'h000000;
      bev_s1_reg <= 20'h00000;
      bev_s2_reg <= 20'h00000;
      msk_s1_reg <= 8'h00;
      msk_s2_reg <= 8'h00;
      be_s1_reg <= 1'b0;
      be_s2_reg <= 1'b0;
      mvp_s1_reg <= 1'b0;
      mvp_s2_reg <= 1'b0;
    end else if (clk_en) begin
      coh_s1_reg <= coherency_global_base_field;
      coh_s2_reg <= coh_s1_reg;
      bev_s1_reg <= boot_exception_vector;
      bev_s2_reg <= bev_s1_reg;
      msk_s1_reg <= boot_overlay_mask;
      msk_s2_reg <= msk_s1_reg;
      be_s1_reg <= endian_flag;
      be_s2_reg <= be_s1_reg;
      mvp_s1_reg <= master_vproc_control;
      mvp_s2_reg <= mvp_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address mask of implemented physical bits 35:15
  wire [20:0] pa_mask;
  genvar gi;
  generate
    for (gi = 0; gi < `SCB_ADDR_W; gi = gi + 1) begin : g_pa
      // PA_BITS counts the implemented bits of the 21-bit base field
      assign pa_mask[gi] = (gi < PA_BITS);
    end
  endgenerate

  // Decode
  wire sel_region = (acc_regnum == `SCB_REGNUM_BASE) && (acc_sel == `SCB_SEL_REGION)
                    && REGION_PRESENT;
  wire sel_coh = (acc_regnum == `SCB_REGNUM_BASE) && (acc_sel == `SCB_SEL_COH)
                 && COH_PRESENT;
  wire sel_boot = (acc_regnum == `SCB_REGNUM_BASE) && (acc_sel == `SCB_SEL_BOOT);
  wire sel_cfg = (acc_regnum == `SCB_REGNUM_CFG) && (acc_sel == `SCB_SEL_CFG);
  wire region_open = !MULTI_VPROC || mvp_s2_reg;

  wire k23_ok, ku_ok, k0_ok;
  scb_attr_check u_k23 (
    .attr_in(acc_wdata[`SCB_K23_HI:`SCB_K23_LO]),
    .supported_set(ATTR_SUPPORTED),
    .attr_ok(k23_ok)
  );
  scb_attr_check u_ku (
    .attr_in(acc_wdata[`SCB_KU_HI:`SCB_KU_LO]),
    .supported_set(ATTR_SUPPORTED),
    .attr_ok(ku_ok)
  );
  scb_attr_check u_k0 (
    .attr_in(acc_wdata[`SCB_K0_HI:0]),
    .supported_set(ATTR_SUPPORTED),
    .attr_ok(k0_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Writable state
  // Address field reset is undefined; zero chosen so outputs are defined
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      region_enable_reg <= 1'b0;
      region_upper_address_reg <= 21'h000000;
      kernel_seg0_attr_reg <= `SCB_K0_RESET;
      user_seg_attr_reg <= `SCB_ATTR_ZERO;
      upper_kernel_seg_attr_reg <= `SCB_ATTR_ZERO;
    end else if (clk_en && acc_wr) begin
      if (sel_region && region_open) begin
        region_upper_address_reg <= acc_wdata[`SCB_ADDR_HI:`SCB_ADDR_LO] & pa_mask;
        region_enable_reg <= acc_wdata[`SCB_EN_BIT];
      end
      if (sel_cfg) begin
        if (FIXED_MMU && k23_ok)
          upper_kernel_seg_attr_reg <= acc_wdata[`SCB_K23_HI:`SCB_K23_LO];
        if (FIXED_MMU && ku_ok)
          user_seg_attr_reg <= acc_wdata[`SCB_KU_HI:`SCB_KU_LO];
        if (k0_ok)
          kernel_seg0_attr_reg <= acc_wdata[`SCB_K0_HI:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read views
  wire [31:0] region_view = region_open ?
    {region_upper_address_reg, region_enable_reg, REGION_MGMT_RSV[0],
     REGION_BLOCKS_M1} : 32'h00000000;
  wire [31:0] coh_view = {coh_s2_reg & pa_mask, 11'h000};
  wire [31:0] boot_view = {bev_s2_reg, 4'h0, msk_s2_reg};
  // Impl bits have no function here, so RMW or zero writes are harmless
  wire [31:0] cfg_view = {1'b1, upper_kernel_seg_attr_reg, user_seg_attr_reg,
    9'h000, be_s2_reg, ARCH_TYPE_VAL, 10'h000,
    kernel_seg0_attr_reg};

  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h00000000;
    if (sel_region)
      rd_next = region_view;
    else if (sel_coh)
      rd_next = coh_view;
    else if (sel_boot)
      rd_next = boot_view;
    else if (sel_cfg)
      rd_next = cfg_view;
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_rdata_reg <= 32'h00000000;
      acc_hit_reg <= 1'b0;
      boot_overlay_reg <= 12'h000;
    end else if (clk_en) begin
      acc_rdata_reg <= acc_rd ? rd_next : 32'h00000000;
      acc_hit_reg <= (acc_rd || acc_wr) && (sel_region || sel_coh || sel_boot || sel_cfg);
      // Non-contiguous masks give an overlay size that is not meaningful
      boot_overlay_reg <= bev_s2_reg[19:8] & {4'hF, ~msk_s2_reg};
    end
  end
endmodule

// file: bench/scb_regs_monitor.sv
// Assertion checker for the register bank, bound into scb_regs and watching the bank's own ports.
// Assumes default parameters and clk_en held high throughout.
`timescale 1ns/1ps
module scb_regs_monitor (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Access port
  input wire acc_rd,
  input wire acc_wr,
  input wire [4:0] acc_regnum,
  input wire [2:0] acc_sel,
  input wire [31:0] acc_wdata,
  input wire [31:0] acc_rdata_reg,
  input wire acc_hit_reg,
  // Pins and region controls
  input wire master_vproc_control,
  input wire region_enable_reg,
  input wire [2:0] kernel_seg0_attr_reg,
  input wire [11:0] boot_overlay_reg
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire at_region = acc_regnum == 5'h0F && acc_sel == 3'h2;
  wire at_cfg = acc_regnum == 5'h10 && acc_sel == 3'h0;
  //////////////////////////////////////////////////////////////////////////////
  a_idle_rd_zero: assert property (!acc_rd |=> acc_rdata_reg == 32'h0)
    else $error("read data not zero without a read");
  a_cfg_top_one: assert property (acc_rd && at_cfg |=> acc_rdata_reg[31] && acc_hit_reg)
    else $error("config bit 31 or hit wrong");
  a_coh_low_zero: assert property (acc_rd && acc_regnum == 5'h0F && acc_sel == 3'h3 |=> acc_rdata_reg[10:0] == 11'h0)
    else $error("coherency low bits not zero");
  a_boot_mid_zero: assert property (acc_rd && acc_regnum == 5'h0F && acc_sel == 3'h4 |=> acc_rdata_reg[11:8] == 4'h0)
    else $error("boot vector bits 11:8 not zero");
  // Four low cycles so the synchronised gate is surely clear
  a_gate_rd_zero: assert property ((!master_vproc_control)[*4] ##0 (acc_rd && at_region) |=> acc_rdata_reg == 32'h0)
    else $error("gated region read not zero");
  a_region_en_wr: assert property (master_vproc_control[*4] ##0 (acc_wr && at_region) |=> region_enable_reg == $past(acc_wdata[10]))
    else $error("region enable did not follow write");
  a_seg0_reset: assert property ($past(sys_rst) |-> kernel_seg0_attr_reg == 3'h2)
    else $error("kernel seg0 attr reset value wrong");
  a_overlay_mask: assert property (acc_rd && acc_regnum == 5'h0F && acc_sel == 3'h4 |=> (boot_overlay_reg[7:0] & acc_rdata_reg[7:0]) == 8'h0)
    else $error("overlay bits not cleared by mask");
endmodule

// file: bench/tb.sv
// Self-checking bench for the register bank; reads are checked from a queue.
// Assumes the bank's default parameters: no reserved block, one block.
`timescale 1ns/1ps
module tb;
  reg mclk, sys_rst, clk_en, acc_rd, acc_wr, master_vproc_control, endian_flag, rd_d;
  reg [4:0] acc_regnum;
  reg [2:0] acc_sel;
  reg [31:0] acc_wdata, w;
  reg [20:0] coherency_global_base_field;
  reg [19:0] boot_exception_vector;
  reg [7:0] boot_overlay_mask;
  wire [31:0] acc_rdata_reg;
  wire acc_hit_reg, region_enable_reg;
  wire [20:0] region_upper_address_reg;
  wire [2:0] kernel_seg0_attr_reg, user_seg_attr_reg, upper_kernel_seg_attr_reg;
  wire [11:0] boot_overlay_reg;
  integer error_cnt, tests_run, i;
  reg [31:0] q[$];
  scb_regs scb_regs_i (.*);
  //////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] exp, input [31:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
    end
  endtask
  task acc(input r, input [4:0] n, input [2:0] s, input [31:0] d, input [31:0] x);
    begin
      @(posedge mclk);
      acc_rd <= r;
      acc_wr <= !r;
      acc_regnum <= n;
      acc_sel <= s;
      acc_wdata <= d;
      if (r)
        q.push_back(x);
      @(posedge mclk);
      acc_rd <= 1'b0;
      acc_wr <= 1'b0;
    end
  endtask
  // Pins pass a two-stage synchroniser, so allow three edges
  task wt;
    repeat (3) @(posedge mclk);
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) rd_d <= acc_rd;
  always @(negedge mclk) if (rd_d) chk(q.pop_front(), acc_rdata_reg);
  initial begin
    repeat (2000) @(posedge mclk);
    error_cnt = error_cnt + 1;
    report_and_stop;
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {sys_rst, clk_en, master_vproc_control} = 3'h7;
    {acc_rd, acc_wr, acc_regnum, acc_sel, acc_wdata, endian_flag, rd_d} = 0;
    {coherency_global_base_field, boot_exception_vector, boot_overlay_mask} = 0;
    error_cnt = 0;
    tests_run = 0;
    w = $urandom(32'hBE309713);
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    chk(32'h2, {29'h0, kernel_seg0_attr_reg});
    wt;
    acc(1, 5'h0F, 3'h2, 0, 32'h0);
    w = $urandom;
    acc(0, 5'h0F, 3'h2, w, 0);
    acc(1, 5'h0F, 3'h2, 0, {w[31:10], 10'h0});
    chk({11'h0, w[31:11], w[10]}, {11'h0, region_upper_address_reg, region_enable_reg});
    master_vproc_control <= 1'b0;
    wt;
    acc(0, 5'h0F, 3'h2, ~w, 0);
    acc(1, 5'h0F, 3'h2, 0, 32'h0);
    master_vproc_control <= 1'b1;
    coherency_global_base_field <= w[20:0];
    wt;
    acc(1, 5'h0F, 3'h2, 0, {w[31:10], 10'h0});
    acc(0, 5'h0F, 3'h3, ~w, 0);
    acc(1, 5'h0F, 3'h3, 0, {w[20:0], 11'h0});
    // Every supported overlay size, smallest first
    for (i = 0; i < 9; i = i + 1) begin
      w = $urandom;
      boot_exception_vector <= w[31:12];
      boot_overlay_mask <= 8'hFF >> (8 - i);
      wt;
      acc(1, 5'h0F, 3'h4, ~w, {w[31:12], 4'h0, 8'hFF >> (8 - i)});
      chk({w[31:28], w[27:20] & ~(8'hFF >> (8 - i))}, {20'h0, boot_overlay_reg});
    end
    endian_flag <= w[0];
    wt;
    acc(0, 5'h10, 3'h0, w, 0);
    acc(1, 5'h10, 3'h0, 0, {1'b1, w[30:25], 9'h0, w[0], 12'h0, w[2:0]});
    chk({23'h0, w[30:25], w[2:0]}, {23'h0, upper_kernel_seg_attr_reg, user_seg_attr_reg, kernel_seg0_attr_reg});
    acc(1, 5'h0F, 3'h0, 0, 32'h0);
    wt;
    report_and_stop;
  end
endmodule
bind scb_regs scb_regs_monitor scb_regs_monitor_i (.*);
